// ===== phm_pkg.sv
// Shared constants for the PHY-side MII data interface
package phm_pkg;

  // Nibble and buffered word layout
  localparam int NIB_W        = 4;          // MII data nibble width
  localparam int WORD_W       = 5;          // Buffered receive word: {error, nibble}
  localparam int WORD_ERR_BIT = 4;          // Position of the error flag in a word
  localparam int TXS_W        = 6;          // Sampled transmit bundle: {er, en, txd}
  localparam int TXS_EN_BIT   = 4;          // Position of transmit enable in the bundle
  localparam int TXS_ER_BIT   = 5;          // Position of transmit error in the bundle

  // Clock rates in kHz as published
  localparam int SYS_CLK_KHZ      = 250000; // Core clock
  localparam int MII_CLK_FAST_KHZ = 25000;  // MII clock at 100 Mbps
  localparam int MII_CLK_SLOW_KHZ = 2500;   // MII clock at 10 Mbps

  // Half periods of the MII clocks in core cycles
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] HALF_FAST =
    DIV_W'(SYS_CLK_KHZ / (2 * MII_CLK_FAST_KHZ));
  localparam logic [DIV_W-1:0] HALF_SLOW =
    DIV_W'(SYS_CLK_KHZ / (2 * MII_CLK_SLOW_KHZ));

  // Values after reset, and the count of a full buffer
  localparam logic [DIV_W-1:0]  RST_DIV  = 6'h00;
  localparam logic [NIB_W-1:0]  RST_NIB  = 4'h0;
  localparam logic [WORD_W-1:0] RST_WORD = 5'h00;
  localparam logic [TXS_W-1:0]  RST_TXS  = 6'h00;
  localparam logic [2:0]        RST_SYNC = 3'h0;
  localparam logic [1:0]        RST_CNT  = 2'h0;
  localparam logic [1:0]        BUF_FULL = 2'h2;   // Entries held by a full buffer

endpackage

// ===== phm_buf_if.sv
// Valid/ready carrier between the receive path and its two-entry buffer
`timescale 1ns/1ns
interface phm_buf_if #(
  parameter int W = phm_pkg::WORD_W
) ();
  logic         in_vld;   // Word offered by the filling side
  logic         in_rdy;   // Buffer can take a word
  logic [W-1:0] in_dat;   // Offered word
  logic         out_vld;  // Buffer holds a word
  logic         out_rdy;  // Draining side takes the word
  logic [W-1:0] out_dat;  // Oldest word, from a register

  // Buffer end
  modport buf_mp (
    input  in_vld,
    input  in_dat,
    input  out_rdy,
    output in_rdy,
    output out_vld,
    output out_dat
  );

  // User end
  modport user_mp (
    output in_vld,
    output in_dat,
    output out_rdy,
    input  in_rdy,
    input  out_vld,
    input  out_dat
  );
endinterface

// ===== phm_buf2.sv
// Two-entry valid/ready buffer in the receive data path
`timescale 1ns/1ns
module phm_buf2 #(
  parameter int W = phm_pkg::WORD_W
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  phm_buf_if.buf_mp bf
);
  import phm_pkg::*;

  // Whole buffer state
  typedef struct packed {
    logic [W-1:0] ent0;   // Oldest entry, drives the read data
    logic [W-1:0] ent1;   // Second entry
    logic [1:0]   cnt;    // Entries in use
  } phm_buf_type;

  phm_buf_type st_r;
  phm_buf_type st_nxt;
  logic        push;
  logic        pop;

  // Ready only while an entry is free, so a full buffer stalls the source
  assign bf.in_rdy  = (st_r.cnt != BUF_FULL);
  assign bf.out_vld = (st_r.cnt != RST_CNT);
  assign bf.out_dat = st_r.ent0;
  assign push       = bf.in_vld & bf.in_rdy;
  assign pop        = bf.out_vld & bf.out_rdy;

  // Next state: shift on pop, fill the first free slot on push
  always_comb begin
    st_nxt = st_r;
    if (push && pop) begin
      if (st_r.cnt == BUF_FULL) begin
        st_nxt.ent0 = st_r.ent1;
        st_nxt.ent1 = bf.in_dat;
      end else begin
        st_nxt.ent0 = bf.in_dat;
      end
    end else if (push) begin
      if (st_r.cnt == RST_CNT) begin
        st_nxt.ent0 = bf.in_dat;
      end else begin
        st_nxt.ent1 = bf.in_dat;
      end
      st_nxt.cnt = st_r.cnt + 2'h1;
    end else if (pop) begin
      st_nxt.ent0 = st_r.ent1;
      st_nxt.cnt  = st_r.cnt - 2'h1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ===== phm_top.sv
// PHY-side MII data interface: clocks, receive path, carrier and collision
`timescale 1ns/1ns
module phm_top (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      line_clk,
  input  wire logic [phm_pkg::NIB_W-1:0] line_rx_nib,
  input  wire logic                      line_rx_vld,
  input  wire logic                      line_rx_err,
  output logic                           line_rx_rdy,
  input  wire logic                      line_carrier,
  input  wire logic                      cfg_speed_100,
  input  wire logic                      cfg_full_duplex,
  output logic                           mii_tx_clk,
  input  wire logic [phm_pkg::NIB_W-1:0] mii_txd,
  input  wire logic                      mii_tx_en,
  input  wire logic                      mii_tx_er,
  output logic                           mii_rx_clk,
  output logic [phm_pkg::NIB_W-1:0]      mii_rxd,
  output logic                           mii_rx_dv,
  output logic                           mii_rx_er,
  output logic                           mii_crs,
  output logic                           mii_col,
  output logic [phm_pkg::NIB_W-1:0]      ln_tx_nib,
  output logic                           ln_tx_en,
  output logic                           ln_tx_er,
  output logic                           ln_tx_stb
);
  import phm_pkg::*;

  // Core-domain state
  typedef struct packed {
    logic [2:0]        spd_s;    // Speed pin synchroniser
    logic [2:0]        fd_s;     // Duplex pin synchroniser
    logic [2:0]        car_s;    // Line carrier synchroniser
    logic [2:0]        req_s;    // Word request toggle synchroniser
    logic [TXS_W-1:0]  tx_s1;    // Transmit pins, first stage
    logic [TXS_W-1:0]  tx_s2;    // Transmit pins, second stage
    logic [TXS_W-1:0]  tx_s3;    // Transmit pins, third stage
    logic              spd_a;    // Agreed speed level
    logic              spd;      // Speed used by the running half period
    logic              fd;       // Agreed full duplex level
    logic              car;      // Agreed line carrier
    logic              tx_act;   // Agreed transmit enable
    logic [DIV_W-1:0]  div;      // Half period counter
    logic              clk;      // MII clock level
    logic              req_seen; // Last request toggle taken
    logic              pend;     // Word held for the buffer
    logic [WORD_W-1:0] word;     // Word copied from the line domain
    logic              ack;      // Acknowledge toggle to the line domain
    logic [NIB_W-1:0]  rxd;      // Receive nibble pins
    logic              rx_dv;    // Receive valid pin
    logic              rx_er;    // Receive error pin
    logic              crs;      // Carrier sense pin
    logic              col;      // Collision pin
    logic [NIB_W-1:0]  ln_nib;   // Sampled transmit nibble
    logic              ln_en;    // Sampled transmit enable
    logic              ln_er;    // Sampled transmit error
    logic              ln_stb;   // One pulse per transmit clock
  } phm_sys_type;

  // Line-domain state
  typedef struct packed {
    logic [2:0]        ack_s;    // Acknowledge toggle synchroniser
    logic              req;      // Request toggle
    logic [WORD_W-1:0] word;     // Word held until acknowledged
    logic              rdy;      // Ready toward the line receiver
  } phm_line_type;

  phm_sys_type  s_r;
  phm_sys_type  s_nxt;
  phm_line_type l_r;
  phm_line_type l_nxt;
  logic [DIV_W-1:0] half_lim;    // Length of the running half period
  logic             tick;        // Last cycle of a half period
  logic             rise;        // MII clock goes high at this edge
  logic             fall;        // MII clock goes low at this edge
  logic             take;        // Line word accepted

  phm_buf_if #(.W(WORD_W)) bf ();

  phm_buf2 #(.W(WORD_W)) u_buf (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .bf      (bf)
  );

  // Divider timing; speed only changes between half periods, so no runt pulse
  assign half_lim = s_r.spd ? HALF_FAST : HALF_SLOW;
  assign tick     = (s_r.div == half_lim - 6'h01);
  assign rise     = tick & ~s_r.clk;
  assign fall     = tick & s_r.clk;

  // Buffer handshake
  assign bf.in_vld  = s_r.pend;
  assign bf.in_dat  = s_r.word;
  assign bf.out_rdy = rise & bf.out_vld;

  // Core-domain next state
  always_comb begin
    s_nxt = s_r;
    // Pin synchronisers: the first stage feeds only the second
    s_nxt.spd_s = {s_r.spd_s[1:0], cfg_speed_100};
    s_nxt.fd_s  = {s_r.fd_s[1:0], cfg_full_duplex};
    s_nxt.car_s = {s_r.car_s[1:0], line_carrier};
    s_nxt.req_s = {s_r.req_s[1:0], l_r.req};
    s_nxt.tx_s1 = {mii_tx_er, mii_tx_en, mii_txd};
    s_nxt.tx_s2 = s_r.tx_s1;
    s_nxt.tx_s3 = s_r.tx_s2;
    // Levels count once the second and third stages agree
    if (s_r.spd_s[1] == s_r.spd_s[2]) begin
      s_nxt.spd_a = s_r.spd_s[2];
    end
    if (s_r.fd_s[1] == s_r.fd_s[2]) begin
      s_nxt.fd = s_r.fd_s[2];
    end
    if (s_r.car_s[1] == s_r.car_s[2]) begin
      s_nxt.car = s_r.car_s[2];
    end
    if (s_r.tx_s2[TXS_EN_BIT] == s_r.tx_s3[TXS_EN_BIT]) begin
      s_nxt.tx_act = s_r.tx_s3[TXS_EN_BIT];
    end
    // Clock divider shared by both MII clocks
    if (tick) begin
      s_nxt.div = RST_DIV;
      s_nxt.clk = ~s_r.clk;
      s_nxt.spd = s_r.spd_a;
    end else begin
      s_nxt.div = s_r.div + 6'h01;
    end
    // The MAC changed its pins at the rising edge; half a period later the
    // synchronised copy has settled, so it is taken at the falling edge
    s_nxt.ln_stb = 1'b0;
    if (fall && (s_r.tx_s2 == s_r.tx_s3)) begin
      s_nxt.ln_nib = s_r.tx_s3[NIB_W-1:0];
      s_nxt.ln_en  = s_r.tx_s3[TXS_EN_BIT];
      s_nxt.ln_er  = s_r.tx_s3[TXS_ER_BIT];
      s_nxt.ln_stb = 1'b1;
    end
    // New line word: copy it, it stays stable until acknowledged
    if (!s_r.pend && (s_r.req_s[1] == s_r.req_s[2]) && (s_r.req_s[2] != s_r.req_seen)) begin
      s_nxt.req_seen = s_r.req_s[2];
      s_nxt.word     = l_r.word;
      s_nxt.pend     = 1'b1;
    end
    // Word handed to the buffer; a full buffer holds it here and stalls the line
    if (s_r.pend && bf.in_rdy) begin
      s_nxt.pend = 1'b0;
      s_nxt.ack  = ~s_r.ack;
    end
    // Receive pins change only as the receive clock rises; the MAC samples
    // them on the following rising edge
    if (rise) begin
      s_nxt.rx_dv = bf.out_vld;
      s_nxt.rxd   = bf.out_vld ? bf.out_dat[NIB_W-1:0] : RST_NIB;
      s_nxt.rx_er = bf.out_vld & bf.out_dat[WORD_ERR_BIT];
    end
    // Carrier sense rises at once, falls only on a receive clock edge
    if (s_r.car || (!s_r.fd && s_r.tx_act)) begin
      s_nxt.crs = 1'b1;
    end else if (rise) begin
      s_nxt.crs = 1'b0;
    end
    // Collision runs on the core clock, unrelated to either MII clock
    s_nxt.col = ~s_r.fd & s_r.tx_act & s_r.car;
  end

  // Core-domain register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Line-domain next state: one word in flight, released by the acknowledge
  assign take = line_rx_vld & l_r.rdy;

  always_comb begin
    l_nxt       = l_r;
    l_nxt.ack_s = {l_r.ack_s[1:0], s_r.ack};
    if (take) begin
      l_nxt.word = {line_rx_err, line_rx_nib};
      l_nxt.req  = ~l_r.req;
    end
    // Ready again only once the acknowledge has come back settled
    l_nxt.rdy = ~take & (l_r.req == l_r.ack_s[2]) & (l_r.ack_s[1] == l_r.ack_s[2]);
  end

  // Line-domain register
  always_ff @(posedge line_clk or negedge rst_b) begin
    if (!rst_b) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign mii_tx_clk  = s_r.clk;
  assign mii_rx_clk  = s_r.clk;
  assign mii_rxd     = s_r.rxd;
  assign mii_rx_dv   = s_r.rx_dv;
  assign mii_rx_er   = s_r.rx_er;
  assign mii_crs     = s_r.crs;
  assign mii_col     = s_r.col;
  assign ln_tx_nib   = s_r.ln_nib;
  assign ln_tx_en    = s_r.ln_en;
  assign ln_tx_er    = s_r.ln_er;
  assign ln_tx_stb   = s_r.ln_stb;
  assign line_rx_rdy = l_r.rdy;

  // Fast transmit clock: high for exactly five core cycles
  property p_txclk_fast;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(mii_tx_clk) && s_r.spd |-> mii_tx_clk [*5] ##1 !mii_tx_clk;
  endproperty
  a_txclk_fast: assert property (p_txclk_fast) else $error("fast tx clock half wrong");

  // Slow receive clock: high for exactly fifty core cycles
  property p_rxclk_slow;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(mii_rx_clk) && !s_r.spd |-> ##49 mii_rx_clk ##1 !mii_rx_clk;
  endproperty
  a_rxclk_slow: assert property (p_rxclk_slow) else $error("slow rx clock half wrong");

  // Receive nibble moves only with a rising receive clock
  property p_rxd_sync;
    @(posedge sys_clk) disable iff (!rst_b)
      $changed(mii_rxd) |-> $rose(mii_rx_clk);
  endproperty
  a_rxd_sync: assert property (p_rxd_sync) else $error("rxd changed off clock");

  // A buffered word reaches the pins with receive valid at the next rise
  property p_rxdv_word;
    @(posedge sys_clk) disable iff (!rst_b)
      rise && bf.out_vld |=> mii_rx_dv && (mii_rxd == $past(bf.out_dat[NIB_W-1:0]));
  endproperty
  a_rxdv_word: assert property (p_rxdv_word) else $error("valid word not presented");

  // Receive error moves on the clock and only alongside valid data
  property p_rxer_sync;
    @(posedge sys_clk) disable iff (!rst_b)
      $changed(mii_rx_er) |-> $rose(mii_rx_clk) && (mii_rx_dv || !mii_rx_er);
  endproperty
  a_rxer_sync: assert property (p_rxer_sync) else $error("rx error off clock");

  // Collision follows transmit and carrier together in half duplex
  property p_col_set;
    @(posedge sys_clk) disable iff (!rst_b)
      !s_r.fd && s_r.tx_act && s_r.car |=> mii_col;
  endproperty
  a_col_set: assert property (p_col_set) else $error("collision not raised");

  // No collision in full duplex
  property p_col_fd;
    @(posedge sys_clk) disable iff (!rst_b)
      s_r.fd |=> !mii_col;
  endproperty
  a_col_fd: assert property (p_col_fd) else $error("collision in full duplex");

  // Half duplex transmit raises carrier sense
  property p_crs_tx;
    @(posedge sys_clk) disable iff (!rst_b)
      !s_r.fd && s_r.tx_act |=> mii_crs;
  endproperty
  a_crs_tx: assert property (p_crs_tx) else $error("no carrier on transmit");

  // Full duplex transmit alone never raises carrier sense
  property p_crs_fd;
    @(posedge sys_clk) disable iff (!rst_b)
      s_r.fd && !s_r.car |=> !$rose(mii_crs);
  endproperty
  a_crs_fd: assert property (p_crs_fd) else $error("carrier from transmit in full duplex");

  // Carrier sense falls only with a rising receive clock
  property p_crs_fall;
    @(posedge sys_clk) disable iff (!rst_b)
      $fell(mii_crs) |-> $rose(mii_rx_clk);
  endproperty
  a_crs_fall: assert property (p_crs_fall) else $error("carrier dropped off clock");

  // Fast transmit clock: low for exactly five core cycles as well
  property p_txclk_low;
    @(posedge sys_clk) disable iff (!rst_b)
      $fell(mii_tx_clk) && s_r.spd |-> !mii_tx_clk [*5] ##1 mii_tx_clk;
  endproperty
  a_txclk_low: assert property (p_txclk_low) else $error("fast tx clock low half wrong");

  // Slow receive clock: low for exactly fifty core cycles
  property p_rxclk_low;
    @(posedge sys_clk) disable iff (!rst_b)
      $fell(mii_rx_clk) && !s_r.spd |-> ##49 !mii_rx_clk ##1 mii_rx_clk;
  endproperty
  a_rxclk_low: assert property (p_rxclk_low) else $error("slow rx clock low half wrong");

  // Receiving always raises carrier sense, whatever the duplex
  property p_crs_rx;
    @(posedge sys_clk) disable iff (!rst_b)
      s_r.car |=> mii_crs;
  endproperty
  a_crs_rx: assert property (p_crs_rx) else $error("no carrier on receive");

  // A settled transmit bundle is handed over with its strobe
  property p_tx_take;
    @(posedge sys_clk) disable iff (!rst_b)
      fall && (s_r.tx_s2 == s_r.tx_s3) |=>
        ln_tx_stb && (ln_tx_nib == $past(s_r.tx_s3[NIB_W-1:0]));
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("transmit nibble not taken");

  // One transmit strobe per transmit clock, at its falling edge
  property p_tx_stb;
    @(posedge sys_clk) disable iff (!rst_b)
      ln_tx_stb |-> $fell(mii_tx_clk);
  endproperty
  a_tx_stb: assert property (p_tx_stb) else $error("transmit strobe off clock");

  // Collision ends once the carrier is gone
  property p_col_end;
    @(posedge sys_clk) disable iff (!rst_b)
      !s_r.car |=> !mii_col;
  endproperty
  a_col_end: assert property (p_col_end) else $error("collision outlived carrier");

  // An empty buffer at a rising receive clock shows idle pins
  property p_rx_idle;
    @(posedge sys_clk) disable iff (!rst_b)
      rise && !bf.out_vld |=> !mii_rx_dv && !mii_rx_er;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("valid shown with no word");

  // Main scenarios
  c_rx_frame: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(mii_rx_dv));
  c_col:      cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(mii_col));
  c_tx_nib:   cover property (@(posedge sys_clk) disable iff (!rst_b) ln_tx_stb && ln_tx_en);
  c_stall:    cover property (@(posedge sys_clk) disable iff (!rst_b) s_r.pend && !bf.in_rdy);
  c_fd_tx:    cover property (@(posedge sys_clk) disable iff (!rst_b) s_r.fd && s_r.tx_act);
endmodule

// ===== phm_mac_model.sv
// MAC-side partner model: sends a counted nibble frame, collects receive words
`timescale 1ns/1ns
module phm_mac_model (
  input  wire logic       mii_tx_clk,
  input  wire logic       mii_rx_clk,
  input  wire logic [3:0] mii_rxd,
  input  wire logic       mii_rx_dv,
  input  wire logic       mii_rx_er,
  input  wire logic [7:0] tx_nibs,
  output logic [3:0]      mii_txd,
  output logic            mii_tx_en,
  output logic            mii_tx_er
);
  logic [7:0] idx = 8'h00;   // Nibbles sent so far in this frame
  logic [4:0] rx_q[$];       // Received words, {error, nibble}
  logic [4:0] rx_hold = 5'h00; // Receive pins as they stand mid-period
  logic       dv_hold = 1'b0;  // Receive valid as it stands mid-period

  initial begin
    mii_txd = 4'h0;
    mii_tx_en = 1'b0;
    mii_tx_er = 1'b0;
  end

  // Drive only just after the rising transmit clock; idle data keeps moving
  always @(posedge mii_tx_clk) begin
    if (tx_nibs == 8'h00) begin
      // Frame request withdrawn: ready for the next frame
      idx <= 8'h00;
      mii_tx_en <= 1'b0;
      mii_tx_er <= 1'b0;
      mii_txd <= ~mii_txd;
    end else if (idx < tx_nibs) begin
      // Data nibble, bit 0 least significant, error on the third one
      mii_tx_en <= 1'b1;
      mii_tx_er <= (idx == 8'h02);
      mii_txd <= idx[3:0] + 4'h3;
      idx <= idx + 8'h01;
    end else begin
      // Frame over: enable low, stale data must not look valid
      mii_tx_en <= 1'b0;
      mii_tx_er <= 1'b0;
      mii_txd <= ~mii_txd;
    end
  end

  // The pins move in the same instant as the clock rises, so reading them
  // at that edge would race; keep their settled value from mid-period
  always @(negedge mii_rx_clk) begin
    dv_hold <= mii_rx_dv;
    rx_hold <= {mii_rx_er, mii_rxd};
  end

  // Take receive words on the rising receive clock, as launched one edge before
  always @(posedge mii_rx_clk) begin
    if (dv_hold === 1'b1) begin
      rx_q.push_back(rx_hold);
    end
  end
endmodule

// ===== tb_phm_top.sv
// Testbench for the PHY-side MII data interface
`timescale 1ns/1ns
module tb_phm_top;
  import phm_pkg::*;
  logic             sys_clk = 1'b0;         // Core clock, 4 ns
  logic             line_clk = 1'b0;        // Line clock, 80 ns
  logic             rst_b = 1'b0;           // Reset, active low
  logic [NIB_W-1:0] line_rx_nib = 4'hF;     // Line word nibble
  logic             line_rx_vld = 1'b0;     // Line word offered
  logic             line_rx_err = 1'b1;     // Line word error flag
  logic             line_carrier = 1'b0;    // Line carrier level
  logic             cfg_speed_100 = 1'b1;   // Speed select
  logic             cfg_full_duplex = 1'b0; // Duplex select
  logic [7:0]       tx_nibs = 8'h00;        // Frame length for the MAC model
  logic             line_rx_rdy, mii_tx_clk, mii_tx_en, mii_tx_er, mii_rx_clk;
  logic             mii_rx_dv, mii_rx_er, mii_crs, mii_col, ln_tx_en, ln_tx_er, ln_tx_stb;
  logic [NIB_W-1:0] mii_txd, mii_rxd, ln_tx_nib;
  logic             crs_q = 1'b0;           // Carrier sense one edge ago
  logic             rxc_q = 1'b0;           // Receive clock one edge ago
  logic [4:0]       ln_q[$];                // Nibbles handed to the line side
  int               fails = 0;
  int               total_checks = 0;
  int               n;
  int               p;
  int               t0;
  // Receive rows: word offered on the line beside the word the MAC must see
  logic [9:0] rx_rows [8] = '{10'h000, 10'h1EF, 10'h021, 10'h318,
                              10'h14A, 10'h2B5, 10'h3FF, 10'h108};
  // Carrier rows: {full duplex, carrier, transmitting, crs, col}
  logic [4:0] cc_rows [6] = '{5'h0A, 5'h0F, 5'h1E, 5'h14, 5'h06, 5'h00};

  phm_top phm_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .line_clk(line_clk),
    .line_rx_nib(line_rx_nib), .line_rx_vld(line_rx_vld), .line_rx_err(line_rx_err),
    .line_rx_rdy(line_rx_rdy), .line_carrier(line_carrier), .cfg_speed_100(cfg_speed_100),
    .cfg_full_duplex(cfg_full_duplex), .mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd),
    .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_rx_clk(mii_rx_clk),
    .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_crs(mii_crs),
    .mii_col(mii_col), .ln_tx_nib(ln_tx_nib), .ln_tx_en(ln_tx_en), .ln_tx_er(ln_tx_er),
    .ln_tx_stb(ln_tx_stb));
  phm_mac_model phm_mac_model_inst (.mii_tx_clk(mii_tx_clk), .mii_rx_clk(mii_rx_clk),
    .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .tx_nibs(tx_nibs),
    .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er));

  // Clocks: the line clock starts off phase so edges never line up
  always #2 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #40 line_clk = ~line_clk;
  end

  // One comparison, counted; a mismatch reported at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Let speed, duplex or carrier changes pass the synchronisers and a slow half period
  task automatic settle();
    repeat (120) @(negedge sys_clk);
  endtask

  // Offer one line word and hold it until taken; afterwards the lines show junk
  task automatic send_word(input logic [4:0] w);
    int k;
    @(negedge line_clk);
    {line_rx_err, line_rx_nib} = w;
    line_rx_vld = 1'b1;
    @(posedge line_clk);
    for (k = 0; k < 64 && line_rx_rdy !== 1'b1; k++) @(posedge line_clk);
    @(negedge line_clk);
    line_rx_vld = 1'b0;
    {line_rx_err, line_rx_nib} = ~w;
  endtask

  // Gather transmit nibbles as the strobe hands them over
  always @(posedge sys_clk) begin
    if (ln_tx_stb === 1'b1 && ln_tx_en === 1'b1) ln_q.push_back({ln_tx_er, ln_tx_nib});
  end

  // Carrier sense may drop only at an edge where the receive clock rises
  always @(posedge sys_clk) begin
    if (crs_q === 1'b1 && mii_crs === 1'b0 && rst_b === 1'b1) begin
      chk({15'h0, mii_rx_clk & ~rxc_q}, 16'h0001);
    end
    crs_q = mii_crs;
    rxc_q = mii_rx_clk;
  end

  // Counts, verdict and the end of the run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need well under a third of this
  initial begin
    #300000;
    fails++;
    test_done();
  end

  initial begin
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    settle();
    // Receive rows at both speeds, clock rates first
    for (int s = 0; s < 2; s++) begin
      cfg_speed_100 = (s == 0);
      settle();
      @(posedge mii_tx_clk);
      t0 = $time;
      @(posedge mii_tx_clk);
      p = $time - t0;
      chk(16'(p), (s == 0) ? 16'(HALF_FAST) * 16'd8 : 16'(HALF_SLOW) * 16'd8);
      chk({15'h0, mii_rx_clk}, {15'h0, mii_tx_clk});
      phm_mac_model_inst.rx_q.delete();
      foreach (rx_rows[i]) send_word(rx_rows[i][9:5]);
      // At 10 Mbps up to four words still wait in the pipe, 400 ns each
      repeat (6) settle();
      chk(16'(phm_mac_model_inst.rx_q.size()), 16'd8);
      foreach (rx_rows[i]) chk(16'(phm_mac_model_inst.rx_q[i]), 16'(rx_rows[i][4:0]));
      $display("test receive speed %0d done", s);
    end
    // Transmit frame of six nibbles with an error on the third
    cfg_speed_100 = 1'b1;
    settle();
    ln_q.delete();
    tx_nibs = 8'd6;
    settle();
    chk(16'(ln_q.size()), 16'd6);
    foreach (ln_q[i]) chk(16'(ln_q[i]), {11'h0, i == 2, 4'(i + 3)});
    tx_nibs = 8'd0;
    settle();
    $display("test transmit done");
    // Carrier sense and collision over duplex, carrier and transmit
    foreach (cc_rows[i]) begin
      {cfg_full_duplex, line_carrier} = cc_rows[i][4:3];
      tx_nibs = cc_rows[i][2] ? 8'd200 : 8'd0;
      settle();
      chk({14'h0, mii_crs, mii_col}, {14'h0, cc_rows[i][1:0]});
      line_carrier = 1'b0;
      tx_nibs = 8'd0;
      settle();
    end
    $display("test carrier done");
    // Reset in mid-frame with carrier and collision up
    cfg_full_duplex = 1'b0;
    line_carrier = 1'b1;
    tx_nibs = 8'd200;
    settle();
    rst_b = 1'b0;
    @(negedge sys_clk);
    chk({10'h0, mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_crs, mii_col, line_rx_rdy}, 16'h0);
    line_carrier = 1'b0;
    tx_nibs = 8'd0;
    repeat (4) @(negedge line_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    for (n = 0; n < 200 && mii_tx_clk !== 1'b1; n++) @(negedge sys_clk);
    chk(16'(n), 16'(HALF_SLOW));
    $display("test reset done");
    test_done();
  end
endmodule
